// >>> src/tmr2_capture_reload_baud.sv
// third 16-bit timer/counter: capture, auto-reload, baud generator
// assumes sys_clk is the oscillator clock; pin inputs are synchronous
`timescale 1ns/10ps
`include "tmr2_map.svh"

// What this block does
// - select bit picks timer or event counter
// - timer counts every twelve oscillator clocks
// - baud timer counts every two clocks
// - capture mode sets overflow flag on wrap
// - enabled trigger fall copies count into capture pair
// - enabled trigger fall sets external flag
// - auto-reload wrap sets flag and reloads
// - enabled trigger fall also reloads
// - either clock select enters baud mode
// - baud mode wrap reloads from pair
// - serial rate is overflow rate over 16
// - internal baud rate osc over 32 times span
// - no overflow flag in baud mode
// - external flag cleared only by software
// - receive clock from this timer or timer1
// - transmit clock from this timer or timer1
// - receive and transmit sources independent
// - external enable gates trigger edges
// - select bit picks capture or reload
// - baud mode ignores capture/reload select
// - counting only while run bit set
// - baud mode trigger sets flag, no reload
// - interrupt is OR of both flags
module tmr2_capture_reload_baud
    import tmr2_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        count_input,
    input  wire logic        trigger_input,
    input  wire logic        timer1_overflow,
    output tmr2_baud_t       baudTicks_r,
    output logic             irqRequest_r
);

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    tmr2_ctrl_t  ctrl_r;
    logic [15:0] count_r;
    logic [15:0] capture_r;
    logic [3:0]  prescale_r;
    logic        countPrev_r;
    logic        trigPrev_r;
    logic        awHeld_r;
    logic        wHeld_r;
    logic [11:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;

    function automatic logic [15:0] mergeByte(
        input logic [15:0] cur,
        input logic        hi,
        input logic [7:0]  val
    );
        mergeByte = hi ? {val, cur[7:0]} : {cur[15:8], val};
    endfunction : mergeByte

    // one-hot register select, shared by write decode and response codes
    function automatic logic [4:0] regSel(input logic [11:0] a);
        unique case (a)
            `TMR2_OFF_CTRL:   regSel = 5'h01;
            `TMR2_OFF_CNT_LO: regSel = 5'h02;
            `TMR2_OFF_CNT_HI: regSel = 5'h04;
            `TMR2_OFF_CAP_LO: regSel = 5'h08;
            `TMR2_OFF_CAP_HI: regSel = 5'h10;
            default:          regSel = 5'h00;
        endcase
    endfunction : regSel

    function automatic logic isReg(input logic [11:0] a);
        isReg = |regSel(a);
    endfunction : isReg

    // mode decode
    tmr2_mode_t mode;
    logic       baudMode;
    assign baudMode = ctrl_r.receiveClockSelect
                    | ctrl_r.transmitClockSelect;
    always_comb
    begin
        if (baudMode)
            mode = TMR2_BAUD;
        else if (ctrl_r.captureReloadSelect)
            mode = TMR2_CAPTURE;
        else
            mode = TMR2_AUTO_RELOAD;
    end

    // count step source
    logic [3:0] divide;
    logic       prescaleHit;
    logic       prescaleOver;
    logic       countFall;
    logic       step;
    assign divide = baudMode ? `TMR2_DIV_STATE
                             : `TMR2_DIV_MACHINE;
    assign prescaleHit = (prescale_r == divide - 4'h1);
    // a switch to the faster rate can leave the prescaler past its end;
    // restart it instead of letting it run round all sixteen values
    assign prescaleOver = (prescale_r > divide - 4'h1);
    assign countFall = countPrev_r & ~count_input;
    assign step = ctrl_r.runControl
                & (ctrl_r.counterTimerSelect ? countFall
                                             : prescaleHit);

    logic wrap;
    assign wrap = step & (count_r == 16'hFFFF);

    logic trigFall;
    logic trigEvent;
    assign trigFall = trigPrev_r & ~trigger_input;
    assign trigEvent = trigFall & ctrl_r.externalTriggerEnable;

    // hardware loads of the count and of the capture/reload pair;
    // in baud mode a trigger edge only sets the flag, it never reloads
    logic reloadNow;
    logic captureNow;
    assign reloadNow = (wrap & (mode != TMR2_CAPTURE))
                     | (trigEvent & (mode == TMR2_AUTO_RELOAD));
    assign captureNow = trigEvent & (mode == TMR2_CAPTURE);

    // bus handshake
    logic wrFire;
    logic rdFire;
    assign wrFire = awHeld_r & wHeld_r & ~s_axi_bvalid;
    assign rdFire = s_axi_arvalid & s_axi_arready;

    logic       wrCtrl;
    logic       wrCntLo;
    logic       wrCntHi;
    logic       wrCapLo;
    logic       wrCapHi;
    logic [7:0] wByte;
    assign wByte = wData_r[7:0];
    // only the low byte lane carries register data
    logic [4:0] wrSel;
    assign wrSel = regSel(awAddr_r) & {5{wrFire & wStrb_r[0]}};
    assign wrCtrl  = wrSel[0];
    assign wrCntLo = wrSel[1];
    assign wrCntHi = wrSel[2];
    assign wrCapLo = wrSel[3];
    assign wrCapHi = wrSel[4];

    // pin samplers; reset to 0 so a pin that idles high shows no false edge
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            countPrev_r <= 1'b0;
            trigPrev_r  <= 1'b0;
        end
        else
        begin
            countPrev_r <= count_input;
            trigPrev_r  <= trigger_input;
        end
    end

    // prescaler stops with the run bit so each start is aligned
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            prescale_r <= 4'h0;
        else if (!ctrl_r.runControl || prescaleHit || prescaleOver)
            prescale_r <= 4'h0;
        else
            prescale_r <= prescale_r + 4'h1;
    end

    // counter: hardware reload wins over a software byte write
    // a count write that meets a step is lost; stop the timer to write
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            count_r <= {`TMR2_RST_BYTE, `TMR2_RST_BYTE};
        else if (reloadNow)
            count_r <= capture_r;
        else if (step)
            count_r <= count_r + 16'h0001;
        else if (wrCntLo)
            count_r <= mergeByte(count_r, 1'b0, wByte);
        else if (wrCntHi)
            count_r <= mergeByte(count_r, 1'b1, wByte);
    end

    // capture/reload pair; in baud mode the trigger never touches it
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            capture_r <= {`TMR2_RST_BYTE, `TMR2_RST_BYTE};
        else if (captureNow)
            capture_r <= count_r;
        else if (wrCapLo)
            capture_r <= mergeByte(capture_r, 1'b0, wByte);
        else if (wrCapHi)
            capture_r <= mergeByte(capture_r, 1'b1, wByte);
    end

    // control: hardware set wins over a software clear
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            ctrl_r <= `TMR2_RST_CTRL;
        else
        begin
            if (wrCtrl)
                ctrl_r <= tmr2_ctrl_t'(wByte);
            if (wrap && !baudMode)
                ctrl_r.overflowFlag <= 1'b1;
            if (trigEvent)
                ctrl_r.externalTriggerFlag <= 1'b1;
        end
    end

    // baud ticks: one pulse per overflow; the serial port divides by 16,
    // giving osc / (2 * span * 16) with the internal clock
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            baudTicks_r <= '0;
        else
        begin
            baudTicks_r.rxBaudTick <= ctrl_r.receiveClockSelect
                ? (wrap & baudMode)
                : timer1_overflow;
            baudTicks_r.txBaudTick <= ctrl_r.transmitClockSelect
                ? (wrap & baudMode)
                : timer1_overflow;
        end
    end

    // the request stays up until software clears both flags
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            irqRequest_r <= 1'b0;
        else
            irqRequest_r <= ctrl_r.overflowFlag
                          | ctrl_r.externalTriggerFlag;
    end

    // address channel: ready pulses once, the address is held until used
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            awHeld_r      <= 1'b0;
            awAddr_r      <= 12'h000;
            s_axi_awready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= ~awHeld_r & ~s_axi_awready
                           & s_axi_awvalid;
            if (wrFire)
                awHeld_r <= 1'b0;
            else if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
        end
    end

    // data channel, independent of the address so either may come first
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wHeld_r      <= 1'b0;
            wData_r      <= 32'h0000_0000;
            wStrb_r      <= 4'h0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_wready <= ~wHeld_r & ~s_axi_wready & s_axi_wvalid;
            if (wrFire)
                wHeld_r <= 1'b0;
            else if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
        end
    end

    // response: raised once both halves are held, kept until taken
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (wrFire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= isReg(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // read channel
    logic [7:0] rdByte;
    always_comb
    begin
        unique case (s_axi_araddr)
            `TMR2_OFF_CTRL:   rdByte = ctrl_r;
            `TMR2_OFF_CNT_LO: rdByte = count_r[7:0];
            `TMR2_OFF_CNT_HI: rdByte = count_r[15:8];
            `TMR2_OFF_CAP_LO: rdByte = capture_r[7:0];
            `TMR2_OFF_CAP_HI: rdByte = capture_r[15:8];
            default:          rdByte = 8'h00;
        endcase
    end

    // address ready only while no answer is pending, so reads never overlap
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid
                           & s_axi_arvalid;
            if (rdFire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rdByte};
                s_axi_rresp  <= isReg(s_axi_araddr) ? RESP_OKAY
                                                    : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule : tmr2_capture_reload_baud

// >>> src/tmr2_map.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the timer module only; the package does not include it
`ifndef TMR2_MAP_SVH
`define TMR2_MAP_SVH

`define TMR2_OFF_CTRL      12'h000
`define TMR2_OFF_CNT_LO    12'h004
`define TMR2_OFF_CNT_HI    12'h008
`define TMR2_OFF_CAP_LO    12'h00C
`define TMR2_OFF_CAP_HI    12'h010

`define TMR2_BIT_OVF       7
`define TMR2_BIT_EXF       6
`define TMR2_BIT_RCLK      5
`define TMR2_BIT_TRANSMIT_CLOCK_SELECT      4
`define TMR2_BIT_EXEN      3
`define TMR2_BIT_RUN       2
`define TMR2_BIT_CT        1
`define TMR2_BIT_CPRL      0

`define TMR2_RST_CTRL      8'h00
`define TMR2_RST_BYTE      8'h00

// oscillator periods per count step
`define TMR2_DIV_MACHINE   4'hC
`define TMR2_DIV_STATE     4'h2

`endif

// >>> src/tmr2_pkg.sv
// types shared by the third timer
// assumes tmr2_map.svh sits next to it
package tmr2_pkg;

    typedef struct packed {
        logic overflowFlag;
        logic externalTriggerFlag;
        logic receiveClockSelect;
        logic transmitClockSelect;
        logic externalTriggerEnable;
        logic runControl;
        logic counterTimerSelect;
        logic captureReloadSelect;
    } tmr2_ctrl_t;

    typedef struct packed {
        logic rxBaudTick;
        logic txBaudTick;
    } tmr2_baud_t;

    typedef enum logic [1:0] {
        TMR2_AUTO_RELOAD,
        TMR2_CAPTURE,
        TMR2_BAUD
    } tmr2_mode_t;

endpackage : tmr2_pkg

// >>> verification/tmr2_far_side.sv
// far side model: trigger and event pins, timer 1 ticks, baud tick counts
// assumes the bench calls fall() and sets t1En; pins idle high
`timescale 1ns/10ps
module tmr2_far_side
    import tmr2_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       t1En,
    input  tmr2_baud_t      ticks,
    output logic            trigPin,
    output logic            cntPin,
    output logic            t1Pulse
);
    int rxCnt = 0;
    int txCnt = 0;
    int gap   = 0;
    initial {trigPin, cntPin} = 2'b11;
    // low and high for three clocks each so the sampler sees both levels
    task automatic fall(input bit trig);
        @(posedge clk);
        if (trig) trigPin <= 1'b0; else cntPin <= 1'b0;
        repeat (3) @(posedge clk);
        trigPin <= 1'b1;
        cntPin  <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : fall
    // one-cycle timer 1 overflow every 20 clocks
    always @(posedge clk)
    begin
        gap     <= (gap == 19) ? 0 : gap + 1;
        t1Pulse <= t1En && gap == 19;
        rxCnt   <= rxCnt + ticks.rxBaudTick;
        txCnt   <= txCnt + ticks.txBaudTick;
    end
endmodule : tmr2_far_side

// >>> verification/tmr2_capture_reload_baud_assertions.sv
// port checker for the third timer
// assumes a single clock domain and the bind below
`timescale 1ns/10ps
module tmr2_capture_reload_baud_assertions
    import tmr2_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input tmr2_baud_t       baudTicks_r,
    input wire logic        irqRequest_r
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    chk_b_answer: assert property (s_axi_awvalid && s_axi_awready
        |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    chk_r_release: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("rvalid held");
    chk_b_release: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("bvalid held");
    chk_rdata_byte: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits");
    chk_tick_pulse: assert property (baudTicks_r.rxBaudTick
        |=> !baudTicks_r.rxBaudTick) else $error("rx tick too long");
    chk_irq_clear: assert property ($fell(irqRequest_r)
        |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("flag cleared without write");
    chk_irq_reset: assert property ($fell(sys_rst)
        |-> !irqRequest_r) else $error("irq after reset");
endmodule : tmr2_capture_reload_baud_assertions

bind tmr2_capture_reload_baud tmr2_capture_reload_baud_assertions chk(.*);

// >>> verification/tmr2_capture_reload_baud_tb_top.sv
// self-checking bench for the third timer
// assumes the far side model and the checker are compiled before it
`timescale 1ns/10ps
module tmr2_capture_reload_baud_tb_top;
    import tmr2_pkg::*;
    logic sys_clk = 0, sys_rst = 1, awv = 0, wv = 0, bre = 0, arv = 0;
    logic rre = 0, awr, wr_, bv, arr, rv, t1En = 0, trig, cnt, t1, irq;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat, d;
    logic [1:0]  bresp, rresp;
    tmr2_baud_t  ticks;
    int n_errors = 0, samples_checked = 0;
    always #5 sys_clk = ~sys_clk;
    tmr2_capture_reload_baud dut(.sys_clk(sys_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .count_input(cnt),
        .trigger_input(trig), .timer1_overflow(t1),
        .baudTicks_r(ticks), .irqRequest_r(irq));
    tmr2_far_side fs(.clk(sys_clk), .t1En(t1En), .ticks(ticks),
        .trigPin(trig), .cntPin(cnt), .t1Pulse(t1));
    task automatic close_out;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic hang;
        n_errors++;
        close_out();
    endtask : hang
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        int i;
        @(posedge sys_clk);
        {awa, wd, awv, wv, bre} <= {a, 24'h0, v, 3'b111};
        for (i = 0; i < 50 && !(bv && bre); i++)
        begin
            @(posedge sys_clk);
            if (awr) awv <= 1'b0;
            if (wr_) wv <= 1'b0;
        end
        if (i == 50) hang();
        bre <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        int i;
        @(posedge sys_clk);
        {ara, arv, rre} <= {a, 2'b11};
        for (i = 0; i < 50 && !(rv && rre); i++)
        begin
            @(posedge sys_clk);
            if (arr) arv <= 1'b0;
        end
        if (i == 50) hang();
        v = rdat;
        rre <= 1'b0;
    endtask : rd
    task automatic expect_reg(input logic [11:0] a, input logic [7:0] e);
        rd(a, d);
        chk(d, {24'h0, e});
    endtask : expect_reg
    task automatic t_reload;
        wr(12'h00C, 8'h00); wr(12'h010, 8'h00);
        wr(12'h004, 8'hFE); wr(12'h008, 8'hFF);
        wr(12'h000, 8'h04);
        repeat (40) @(posedge sys_clk);
        expect_reg(12'h000, 8'h84);
        expect_reg(12'h008, 8'h00);
        chk(irq, 1);
        wr(12'h000, 8'h00);
        expect_reg(12'h000, 8'h00);
        wr(12'h004, 8'h55);
        repeat (30) @(posedge sys_clk);
        expect_reg(12'h004, 8'h55);
        chk(irq, 0);
        $display("reload test done");
    endtask : t_reload
    task automatic t_trigger;
        wr(12'h000, 8'h09); wr(12'h004, 8'h3C); wr(12'h008, 8'hA5);
        fs.fall(1);
        expect_reg(12'h00C, 8'h3C);
        expect_reg(12'h010, 8'hA5);
        expect_reg(12'h000, 8'h49);
        wr(12'h000, 8'h01); wr(12'h004, 8'h11);
        fs.fall(1);
        expect_reg(12'h00C, 8'h3C);
        expect_reg(12'h000, 8'h01);
        wr(12'h000, 8'h08); wr(12'h004, 8'h77);
        fs.fall(1);
        expect_reg(12'h004, 8'h3C);
        expect_reg(12'h000, 8'h48);
        wr(12'h000, 8'h00); wr(12'h004, 8'h00); wr(12'h000, 8'h06);
        repeat (5) fs.fall(0);
        expect_reg(12'h004, 8'h05);
        $display("trigger test done");
    endtask : t_trigger
    task automatic t_baud;
        int r0, x0;
        wr(12'h000, 8'h00); wr(12'h00C, 8'hF0); wr(12'h010, 8'hFF);
        wr(12'h004, 8'hF0); wr(12'h008, 8'hFF);
        t1En <= 1'b1;
        wr(12'h000, 8'h24);
        {r0, x0} = {fs.rxCnt, fs.txCnt};
        repeat (320) @(posedge sys_clk);
        r0 = fs.rxCnt - r0;
        x0 = fs.txCnt - x0;
        chk(r0 >= 9 && r0 <= 11, 1);
        chk(x0 >= 15 && x0 <= 17, 1);
        expect_reg(12'h000, 8'h24);
        chk(irq, 0);
        rd(12'h014, d);
        chk(d, 32'h0);
        chk({30'h0, rresp}, 32'h2);
        wr(12'h014, 8'h00);
        chk({30'h0, bresp}, 32'h2);
        wr(12'h000, 8'h24);
        chk({30'h0, bresp}, 32'h0);
        $display("baud test done");
    endtask : t_baud
    initial
    begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        expect_reg(12'h000, 8'h00);
        t_reload();
        t_trigger();
        t_baud();
        close_out();
    end
endmodule : tmr2_capture_reload_baud_tb_top
